// ===== design/fmt_pkg.sv
// Shared constants and types for the load/store formatting datapath
package fmt_pkg;

   // Data widths
   localparam int unsigned QW = 64;
   localparam int unsigned LW = 32;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned VA_BITS = 43; // Implemented virtual address bits

   // Operation codes; anything not listed is refused
   typedef enum logic [3:0] {
      OP_LDL = 4'h0, // Longword load, sign-extended
      OP_LDQ = 4'h1, // Quadword load
      OP_STL = 4'h2, // Longword store
      OP_STQ = 4'h3, // Quadword store
      OP_LDF = 4'h4, // Legacy single float load
      OP_STF = 4'h5, // Legacy single float store
      OP_EXT = 4'h6, // Byte/word extract
      OP_INS = 4'h7, // Byte/word insert
      OP_MSK = 4'h8, // Byte mask, word size refused
      OP_ZAP = 4'h9, // zero_bytes_op
      OP_ADDL = 4'ha, // Longword add
      OP_ADDQ = 4'hb, // Quadword add
      OP_CMPLT = 4'hc, // Signed quadword compare
      OP_CMPULT = 4'hd, // Unsigned quadword compare
      OP_FCHK = 4'he // Float operand consume/check
   } op_t;

   // Memory layout of a legacy single float
   localparam int unsigned MEM_SIGN = 15;
   localparam int unsigned MEM_EXP_HI = 14;
   localparam int unsigned MEM_EXP_LO = 7;
   localparam int unsigned MEM_FHI_HI = 6;
   localparam int unsigned MEM_FLO_HI = 31;
   localparam int unsigned MEM_FLO_LO = 16;

   // Register layout of the widened float
   localparam int unsigned REG_SIGN = 63;
   localparam int unsigned REG_EXP_HI = 62;
   localparam int unsigned REG_EXP_LO = 52;
   localparam int unsigned REG_EXP_MID = 58;
   localparam int unsigned REG_FHI_HI = 51;
   localparam int unsigned REG_FHI_LO = 45;
   localparam int unsigned REG_FLO_HI = 44;
   localparam int unsigned REG_FLO_LO = 29;
   localparam int unsigned REG_PAD_W = 29;

   // Exponent widening fill patterns
   localparam logic [2:0] EXP_FILL_HI = 3'h0;
   localparam logic [2:0] EXP_FILL_LO = 3'h7;

   // Lane masks for byte and word operands
   localparam logic [7:0] LANE_BYTE = 8'h01;
   localparam logic [7:0] LANE_WORD = 8'h03;

   // Reset values
   localparam logic [63:0] RES_RST = 64'h0;

endpackage : fmt_pkg

// ===== design/ffloat_conv.sv
// Legacy single float widening on load and repacking on store
`timescale 1ns/1ps

module ffloat_conv
   import fmt_pkg::*;
(
   // Memory image in, widened register out
   input wire logic [31:0] i_mem,
   output logic [63:0] o_reg,
   // Register image in, packed memory image out
   input wire logic [63:0] i_reg,
   output logic [31:0] o_mem,
   // Operand class of the register image
   output logic o_reg_reserved
);

   logic [7:0] mexp;
   logic [10:0] wexp;
   logic msign;
   logic rzero;

   assign mexp = i_mem[MEM_EXP_HI:MEM_EXP_LO];
   assign msign = i_mem[MEM_SIGN];

   // Widen 8-bit excess-128 code to 11 bits; codes 1..255 gain 896, zero stays zero
   always_comb begin
      if (mexp[7]) begin
         wexp = {1'b1, EXP_FILL_HI, mexp[6:0]}; // see [RL12] see [RL18]
      end else if (mexp != 8'h00) begin
         wexp = {1'b0, EXP_FILL_LO, mexp[6:0]}; // see [RL12]
      end else begin
         wexp = 11'h000; // see [RL12]
      end
   end

   // Sign on top, exponent, then fraction high then low part; pad zero
   // A true zero loads canonically, whatever its stored fraction
   always_comb begin
      if (mexp == 8'h00 && !msign) begin
         o_reg = 64'h0; // see [RL16] see [RL17]
      end else begin
         o_reg = {msign, wexp, i_mem[MEM_FHI_HI:0], // see [RL20] see [RL10] see [RL15]
                  i_mem[MEM_FLO_HI:MEM_FLO_LO], {REG_PAD_W{1'b0}}}; // see [RL11] see [RL9]
      end
   end

   // Store drops bits 61:59 and 28:0 from the image; 61:59 still feed rzero
   assign rzero = (i_reg[REG_EXP_HI:REG_EXP_LO] == 11'h000);
   assign o_reg_reserved = rzero & i_reg[REG_SIGN]; // see [RL19]

   always_comb begin
      if (rzero && !i_reg[REG_SIGN]) begin
         o_mem = 32'h0; // see [RL17]
      end else begin
         o_mem = {i_reg[REG_FLO_HI:REG_FLO_LO], i_reg[REG_SIGN], // see [RL13] see [RL14]
                  i_reg[REG_EXP_HI], i_reg[REG_EXP_MID:REG_EXP_LO],
                  i_reg[REG_FHI_HI:REG_FHI_LO]}; // see [RL15]
      end
   end

endmodule : ffloat_conv

// ===== design/fmt_datapath.sv
// Load/store formatting datapath for integer and legacy single float data
//
// How it works
// [RL1] A byte is eight bits, lane-aligned, bit 0 least significant.
// [RL2] A word is two bytes, bits 0-15, addressed by its low byte.
// [RL3] Only extract, mask, insert and zero-bytes operations touch single bytes.
// [RL4] Words are handled only by extract and insert.
// [RL5] A longword is 32 bits, two's complement, sign in bit 31.
// [RL6] Longwords load sign-extended, store, or use longword arithmetic.
// [RL7] A quadword is 64 bits, signed with bit 63 or unsigned.
// [RL8] Virtual addresses are 64 bits; at least 43 are implemented.
// [RL9] A loaded float fills the 64-bit register left-justified.
// [RL10] Float load reorders bits and widens exponent from eight to eleven.
// [RL11] Register fraction bits not supplied by memory load as zero.
// [RL12] Exponent widening: top 1 gets 000, nonzero top 0 gets 111.
// [RL13] Float store repacks, ignoring register bits 61:59 and 28:0; the zero and reserved tests here still read 61:59.
// [RL14] Memory sign sits in bit 15, excess-128 exponent in 14:7.
// [RL15] Memory fraction is 24 bits hidden-lead, in 31:16 then 6:0.
// [RL16] Exponent zero with sign zero means the value zero.
// [RL17] A zero result is always emitted as all-zero bits; a float store with exponent zero but bits 61:59 set keeps its fraction.
// [RL18] Exponent codes 1 to 255 mean exponents -127 to 127.
// [RL19] Exponent zero with sign one is reserved and raises an exception.
// [RL20] Loaded sign goes to bit 63, exponent 62:52, fraction below.
// [RL21] Each conversion completes in one pass with no extra handshake.
`timescale 1ns/1ps

module fmt_datapath
   import fmt_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RSTN,
   // Request
   input wire logic i_REQ_VALID,
   input wire logic [3:0] i_OP,
   input wire logic i_SIZE_WORD,
   input wire logic [63:0] i_ADDR,
   // Operands
   input wire logic [63:0] i_MEM_DATA,
   input wire logic [63:0] i_REG_A,
   input wire logic [63:0] i_REG_B,
   // Result
   output logic o_RES_VALID,
   output logic [63:0] o_RES_DATA,
   output logic o_ARITH_EXC,
   output logic o_ILLEGAL_OP,
   output logic o_ADDR_FAULT
);

   ////////////////////////////////////////////////////////////////////////
   // Operand decode

   op_t op;
   logic [5:0] shamt;
   logic [7:0] lane_mask;
   logic [63:0] size_mask;
   logic [63:0] msk_val;
   logic [63:0] zap_val;
   logic [31:0] addl_sum;
   logic [63:0] fl_reg;
   logic [31:0] fl_mem;
   logic fl_reserved;
   logic va_ok;
   logic is_mem;

   assign op = op_t'(i_OP);

   // Byte offset within the quadword, in bits
   assign shamt = {i_ADDR[2:0], 3'b000}; // see [RL1] see [RL2]

   // Word ops only exist for extract and insert; word-sized mask is refused
   assign lane_mask = i_SIZE_WORD ? (LANE_WORD << i_ADDR[2:0])
                                  : (LANE_BYTE << i_ADDR[2:0]); // see [RL2]
   assign size_mask = i_SIZE_WORD ? 64'h0000_0000_0000_ffff
                                  : 64'h0000_0000_0000_00ff; // see [RL1]

   // Upper address bits must copy bit 42 of the implemented range
   assign va_ok = (&i_ADDR[63:VA_BITS-1]) | ~(|i_ADDR[63:VA_BITS-1]); // see [RL8]
   assign is_mem = (op == OP_LDL) || (op == OP_LDQ) || (op == OP_STL) ||
                   (op == OP_STQ) || (op == OP_LDF) || (op == OP_STF);

   assign addl_sum = i_REG_A[31:0] + i_REG_B[31:0]; // see [RL5]

   // Per-lane clearing for mask and zero-bytes operations
   for (genvar b = 0; b < 8; b++) begin : g_lane
      assign msk_val[b*BYTE_W +: BYTE_W] = lane_mask[b] ? 8'h00 : i_REG_A[b*BYTE_W +: BYTE_W]; // see [RL3]
      assign zap_val[b*BYTE_W +: BYTE_W] = i_REG_B[b] ? 8'h00 : i_REG_A[b*BYTE_W +: BYTE_W]; // see [RL3]
   end

   // Float conversion, shared by load, store and operand check
   ffloat_conv u_conv (
      .i_mem(i_MEM_DATA[31:0]),
      .o_reg(fl_reg),
      .i_reg(i_REG_A),
      .o_mem(fl_mem),
      .o_reg_reserved(fl_reserved)
   );

   ////////////////////////////////////////////////////////////////////////
   // Result selection

   logic [63:0] res_d;
   logic ill_d;
   logic exc_d;
   logic fault_d;

   // Word-sized mask and byte loads are not offered; undefined codes refuse
   always_comb begin
      res_d = RES_RST;
      ill_d = 1'b0;
      exc_d = 1'b0;
      fault_d = 1'b0;
      case (op)
         OP_LDL: begin
            res_d = {{32{i_MEM_DATA[31]}}, i_MEM_DATA[31:0]}; // see [RL6] see [RL5]
         end
         OP_LDQ: begin
            res_d = i_MEM_DATA; // see [RL7]
         end
         OP_STL: begin
            res_d = {32'h0, i_REG_A[31:0]}; // see [RL6]
         end
         OP_STQ: begin
            res_d = i_REG_A;
         end
         OP_LDF: begin
            res_d = fl_reg; // see [RL9] see [RL21]
         end
         OP_STF: begin
            res_d = {32'h0, fl_mem}; // see [RL13]
            exc_d = fl_reserved; // see [RL19]
         end
         OP_EXT: begin
            res_d = (i_REG_A >> shamt) & size_mask; // see [RL3] see [RL4]
         end
         OP_INS: begin
            res_d = (i_REG_A & size_mask) << shamt; // see [RL3] see [RL4]
         end
         OP_MSK: begin
            if (i_SIZE_WORD) begin
               ill_d = 1'b1; // see [RL4]
            end else begin
               res_d = msk_val; // see [RL3]
            end
         end
         OP_ZAP: begin
            res_d = zap_val; // see [RL3]
         end
         OP_ADDL: begin
            res_d = {{32{addl_sum[31]}}, addl_sum}; // see [RL5] see [RL6]
         end
         OP_ADDQ: begin
            res_d = i_REG_A + i_REG_B; // see [RL7]
         end
         OP_CMPLT: begin
            res_d = {63'h0, $signed(i_REG_A) < $signed(i_REG_B)}; // see [RL7]
         end
         OP_CMPULT: begin
            res_d = {63'h0, i_REG_A < i_REG_B}; // see [RL7]
         end
         OP_FCHK: begin
            res_d = i_REG_A;
            exc_d = fl_reserved; // see [RL19]
         end
         default: begin
            ill_d = 1'b1; // see [RL3]
         end
      endcase
      // Memory ops with an unimplemented address never reach memory
      if (is_mem && !va_ok) begin
         fault_d = 1'b1; // see [RL8]
         res_d = RES_RST;
         exc_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result registers

   // One request, one result one cycle later; nothing is ever held back
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         o_RES_VALID <= 1'b0;
      end else begin
         o_RES_VALID <= i_REQ_VALID; // see [RL21]
      end
   end

   // Data only moves on a request, so idle cycles keep the last answer
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         o_RES_DATA <= RES_RST;
      end else if (i_REQ_VALID) begin
         o_RES_DATA <= res_d;
      end
   end

   // Flags are per result, cleared on idle cycles
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         o_ARITH_EXC <= 1'b0;
         o_ILLEGAL_OP <= 1'b0;
         o_ADDR_FAULT <= 1'b0;
      end else begin
         o_ARITH_EXC <= i_REQ_VALID & exc_d;
         o_ILLEGAL_OP <= i_REQ_VALID & ill_d;
         o_ADDR_FAULT <= i_REQ_VALID & fault_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // Copies of the request for relating answers to their cause
   logic chk_v_q;
   logic [3:0] chk_op_q;
   logic chk_word_q;
   logic chk_va_q;
   logic [63:0] chk_mem_q;
   logic [63:0] chk_a_q;
   logic [63:0] chk_b_q;

   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         chk_v_q <= 1'b0;
         chk_op_q <= 4'h0;
         chk_word_q <= 1'b0;
         chk_va_q <= 1'b0;
         chk_mem_q <= 64'h0;
         chk_a_q <= 64'h0;
         chk_b_q <= 64'h0;
      end else begin
         chk_v_q <= i_REQ_VALID;
         chk_op_q <= i_OP;
         chk_word_q <= i_SIZE_WORD;
         chk_va_q <= va_ok;
         chk_mem_q <= i_MEM_DATA;
         chk_a_q <= i_REG_A;
         chk_b_q <= i_REG_B;
      end
   end

   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RSTN);

   a_byte_ext_width: assert property ( // see [RL1]
      (chk_v_q && chk_op_q == OP_EXT && !chk_word_q) |-> (o_RES_DATA[63:8] == 56'h0))
      else $error("byte extract leaked above bit 7");

   a_word_ext_width: assert property ( // see [RL2]
      (chk_v_q && chk_op_q == OP_EXT && chk_word_q) |-> (o_RES_DATA[63:16] == 48'h0))
      else $error("word extract leaked above bit 15");

   a_bad_op_refused: assert property ( // see [RL3]
      (i_REQ_VALID && i_OP == 4'hf) |=> (o_ILLEGAL_OP && o_RES_VALID))
      else $error("undefined operation not refused");

   a_word_msk_refused: assert property ( // see [RL4]
      (i_REQ_VALID && i_OP == OP_MSK && i_SIZE_WORD) |=> o_ILLEGAL_OP)
      else $error("word mask not refused");

   a_long_sign_ext: assert property ( // see [RL6]
      (chk_v_q && chk_op_q == OP_LDL && chk_va_q)
      |-> (o_RES_DATA == {{32{chk_mem_q[31]}}, chk_mem_q[31:0]}))
      else $error("longword load not sign-extended");

   a_addl_sign: assert property ( // see [RL5]
      (chk_v_q && chk_op_q == OP_ADDL) |-> (o_RES_DATA[63:31] == {33{o_RES_DATA[31]}}))
      else $error("longword sum not sign-extended from bit 31");

   a_quad_unsigned: assert property ( // see [RL7]
      (chk_v_q && chk_op_q == OP_CMPULT) |-> (o_RES_DATA[0] == (chk_a_q < chk_b_q)))
      else $error("unsigned compare wrong");

   a_va_fault: assert property ( // see [RL8]
      (i_REQ_VALID && i_OP == OP_LDQ && i_ADDR[63] != i_ADDR[42])
      |=> (o_ADDR_FAULT && o_RES_DATA == 64'h0))
      else $error("unimplemented address not faulted");

   a_fload_pad_zero: assert property ( // see [RL11]
      (chk_v_q && chk_op_q == OP_LDF && chk_va_q) |-> (o_RES_DATA[28:0] == 29'h0))
      else $error("float load left low fraction bits set");

   a_exp_widen: assert property ( // see [RL12]
      (chk_v_q && chk_op_q == OP_LDF && chk_va_q && chk_mem_q[14:7] != 8'h00)
      |-> (o_RES_DATA[61:59] == {3{~chk_mem_q[14]}} && o_RES_DATA[62] == chk_mem_q[14]
           && o_RES_DATA[58:52] == chk_mem_q[13:7]))
      else $error("exponent widening wrong");

   a_fload_layout: assert property ( // see [RL20]
      (chk_v_q && chk_op_q == OP_LDF && chk_va_q && chk_mem_q[14:7] != 8'h00)
      |-> (o_RES_DATA[63] == chk_mem_q[15] && o_RES_DATA[51:45] == chk_mem_q[6:0]
           && o_RES_DATA[44:29] == chk_mem_q[31:16]))
      else $error("float load field placement wrong");

   a_fstore_pack: assert property ( // see [RL13]
      (chk_v_q && chk_op_q == OP_STF && chk_va_q && chk_a_q[62:52] != 11'h000)
      |-> (o_RES_DATA[31:0] == {chk_a_q[44:29], chk_a_q[63], chk_a_q[62],
                                chk_a_q[58:52], chk_a_q[51:45]}))
      else $error("float store repack wrong");

   a_canon_zero: assert property ( // see [RL16]
      (i_REQ_VALID && i_OP == OP_LDF && va_ok && i_MEM_DATA[15:7] == 9'h000)
      |=> (o_RES_DATA == 64'h0))
      else $error("zero float not loaded canonically");

   a_reserved_exc: assert property ( // see [RL19]
      (i_REQ_VALID && i_OP == OP_FCHK && i_REG_A[63] && i_REG_A[62:52] == 11'h000)
      |=> o_ARITH_EXC ##1 (o_ARITH_EXC == $past(i_REQ_VALID && exc_d)))
      else $error("reserved operand not trapped");

   a_single_pass: assert property ( // see [RL21]
      i_REQ_VALID |=> o_RES_VALID)
      else $error("result not delivered in one cycle");

   c_float_load: cover property (i_REQ_VALID && i_OP == OP_LDF ##1 o_RES_VALID);
   c_reserved_trap: cover property (o_ARITH_EXC);
   c_zap_lanes: cover property (i_REQ_VALID && i_OP == OP_ZAP && i_REG_B[7:0] == 8'h5a);
   c_back_to_back: cover property (i_REQ_VALID [*3]);

endmodule : fmt_datapath

// ===== test/fmt_partner.sv
// Far-side model: memory pipeline holding eight quadword slots
`timescale 1ns/1ps

module fmt_partner (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Request seen by the datapath
   input wire logic i_req_valid,
   input wire logic [3:0] i_op,
   input wire logic [63:0] i_addr,
   // Result returned by the datapath
   input wire logic i_res_valid,
   input wire logic [63:0] i_res_data,
   input wire logic i_fault,
   // Aligned load data
   output logic [63:0] o_mem_data
);
   logic [63:0] mem_q [8];
   logic [63:0] last_q;
   logic [3:0] op_q;
   logic [2:0] slot_q;

   ////////////////////////////////////////////////////////////////////////////
   // Capture request, write store images back on the result
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < 8; i++) mem_q[i] <= 64'h0;
         last_q <= 64'h0;
         op_q <= 4'h0;
         slot_q <= 3'h0;
      end else begin
         if (i_req_valid) begin
            op_q <= i_op;
            slot_q <= i_addr[5:3];
            last_q <= o_mem_data;
         end
         // Faulted stores never reach memory
         if (i_res_valid && !i_fault) begin
            if (op_q == 4'h2 || op_q == 4'h5) mem_q[slot_q][31:0] <= i_res_data[31:0];
            if (op_q == 4'h3) mem_q[slot_q] <= i_res_data;
         end
      end
   end

   // Idle bus shows inverted data so stale values cannot match
   assign o_mem_data = i_req_valid ? mem_q[i_addr[5:3]] : ~last_q;
endmodule : fmt_partner

// ===== test/float_load_store_format_test.sv
// Self-checking bench for the load/store formatting datapath
`timescale 1ns/1ps

module float_load_store_format_test;
   import fmt_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   logic [3:0] op = 4'h0;
   logic size_word = 1'b0;
   logic [63:0] addr = 64'h0;
   logic [63:0] reg_a = 64'h0;
   logic [63:0] reg_b = 64'h0;
   logic [63:0] mem_data;
   logic res_valid;
   logic [63:0] res_data;
   logic arith_exc;
   logic illegal_op;
   logic addr_fault;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [67:0] expq [$];

   always #25 clk = ~clk;

   fmt_datapath DUT (.I_CLK_SYS(clk), .I_RSTN(rstn), .i_REQ_VALID(req_valid), .i_OP(op),
      .i_SIZE_WORD(size_word), .i_ADDR(addr), .i_MEM_DATA(mem_data), .i_REG_A(reg_a), .i_REG_B(reg_b),
      .o_RES_VALID(res_valid), .o_RES_DATA(res_data), .o_ARITH_EXC(arith_exc), .o_ILLEGAL_OP(illegal_op),
      .o_ADDR_FAULT(addr_fault));

   fmt_partner far (.i_clk(clk), .i_rstn(rstn), .i_req_valid(req_valid), .i_op(op), .i_addr(addr),
      .i_res_valid(res_valid), .i_res_data(res_data), .i_fault(addr_fault), .o_mem_data(mem_data));

   ////////////////////////////////////////////////////////////////////////////
   // Reference model: {skip data, fault, illegal, exception, data}
   function automatic logic [67:0] model(logic [3:0] o, logic sw, logic [63:0] ad, m, a, b);
      logic [63:0] d;
      logic [63:0] ln;
      logic [5:0] sh;
      logic [7:0] e8;
      logic [10:0] x;
      logic e;
      logic il;
      logic f;
      logic sk;
      d = 64'h0;
      e = 1'b0;
      il = 1'b0;
      sk = 1'b0;
      sh = {ad[2:0], 3'h0};
      ln = sw ? 64'hffff : 64'hff;
      f = (o <= 4'h5) && !((&ad[63:42]) || !(|ad[63:42]));
      case (o)
         4'h0: d = {{32{m[31]}}, m[31:0]};
         4'h1: d = m;
         4'h2: d = {32'h0, a[31:0]};
         4'h3: d = a;
         4'h4: begin
            e8 = m[14:7];
            x = e8[7] ? {4'h8, e8[6:0]} : ((|e8) ? {4'h7, e8[6:0]} : 11'h0);
            d = (e8 == 8'h0 && !m[15]) ? 64'h0 : {m[15], x, m[6:0], m[31:16], 29'h0};
         end
         4'h5: begin
            e8 = {a[62], a[58:52]};
            e = a[63] && e8 == 8'h0;
            sk = e;
            d = (e8 == 8'h0) ? 64'h0 : {32'h0, a[44:29], a[63], e8, a[51:45]};
         end
         4'h6: d = (a >> sh) & ln;
         4'h7: d = (a & ln) << sh;
         4'h8: begin
            il = sw;
            d = a & ~(ln << sh);
         end
         4'h9: begin
            d = a;
            for (int i = 0; i < 8; i++) if (b[i]) d[8*i +: 8] = 8'h0;
         end
         4'ha: begin
            d = a + b;
            d = {{32{d[31]}}, d[31:0]};
         end
         4'hb: d = a + b;
         4'hc: d = {63'h0, $signed(a) < $signed(b)};
         4'hd: d = {63'h0, a < b};
         4'he: begin
            e = a[63] && {a[62], a[58:52]} == 8'h0;
            sk = 1'b1;
         end
         default: il = 1'b1;
      endcase
      if (f) begin
         e = 1'b0;
         sk = 1'b0;
      end
      if (f || il) d = 64'h0;
      return {sk, f, il, e, d};
   endfunction : model

   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run

   // One request per call; consecutive calls run back to back
   task automatic req(logic [3:0] o, logic sw, logic [63:0] ad, a, b);
      @(posedge clk);
      #5;
      req_valid = 1'b1;
      op = o;
      size_word = sw;
      addr = ad;
      reg_a = a;
      reg_b = b;
      #1;
      expq.push_back(model(o, sw, ad, mem_data, a, b));
   endtask : req

   task automatic idle();
      @(posedge clk);
      #5;
      req_valid = 1'b0;
   endtask : idle

   ////////////////////////////////////////////////////////////////////////////
   // Result monitor, one cycle after every taken request
   always @(posedge clk) begin : mon
      logic v;
      logic [67:0] r;
      v = req_valid;
      #1;
      if (rstn) begin
         check("valid", {63'h0, res_valid}, {63'h0, v});
         if (v) begin
            r = expq.pop_front();
            if (!r[67]) check("data", res_data, r[63:0]);
            check("flags", {61'h0, addr_fault, illegal_op, arith_exc}, {61'h0, r[66:64]});
         end
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin : main
      logic [7:0] ex [5];
      logic [31:0] m;
      logic [63:0] img;
      logic [63:0] jk;
      logic [63:0] ad;
      logic [3:0] o;
      ex = '{8'hff, 8'h80, 8'h7f, 8'h01, 8'h00};
      void'($urandom(32'h908f76a0));
      repeat (10) @(posedge clk);
      #5;
      check("reset data", res_data, 64'h0);
      check("reset valid", {63'h0, res_valid}, 64'h0);
      repeat (10) @(posedge clk);
      #5;
      rstn = 1'b1;
      // Exponent classes through store, load, check and repack
      foreach (ex[i]) begin
         for (int s = 0; s < 2; s++) begin
            m = {16'($urandom), 1'(s), ex[i], 7'($urandom)};
            req(4'h2, 1'b0, 64'h0, {32'h0, m}, 64'h0);
            idle();
            req(4'h4, 1'b0, 64'h0, 64'h0, 64'h0);
            img = model(4'h4, 1'b0, 64'h0, {32'h0, m}, 64'h0, 64'h0);
            req(4'he, 1'b0, 64'h0, img, 64'h0);
            jk = {$urandom, $urandom} & 64'h3800_0000_1fff_ffff;
            if (ex[i] == 8'h0) jk[61:59] = 3'h0;
            req(4'h5, 1'b0, 64'h8, img ^ jk, 64'h0);
            idle();
         end
      end
      // Random mix of every code, held strobes, faulting addresses
      repeat (400) begin
         o = 4'($urandom);
         ad = {$urandom, $urandom};
         if ($urandom % 4 != 0) ad[63:43] = {21{ad[42]}};
         img = {$urandom, $urandom};
         if (o == 4'h5 || o == 4'he) img = model(4'h4, 1'b0, 64'h0, img, 64'h0, 64'h0);
         req(o, 1'($urandom), ad, img, {$urandom, $urandom});
         if ($urandom % 4 == 0) idle();
      end
      idle();
      repeat (3) @(posedge clk);
      complete_run();
   end
endmodule : float_load_store_format_test
